//--- hw/slm_monitor.sv
`timescale 1ns/100ps
module slm_monitor #(
  parameter int NUM_LANES = 8,
  parameter int COUNT_W = 8
) (
  input wire logic clock_in,
  input wire logic nrst_in,
  input wire logic [10:0] reg_addr_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [7:0] reg_wdata_in,
  output logic [7:0] reg_rdata_out,
  input wire slm_pkg::slm_err_event_t lane_err_in,
  input wire slm_pkg::slm_lane_status_t lane_status_in,
  output logic sync_request_output_n_out,
  output logic irq_n_out
);
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    if (NUM_LANES < 1 || NUM_LANES > 8 || COUNT_W != 8) begin
      $error("slm_monitor: NUM_LANES must be 1..8 and COUNT_W 8");
    end
  end

  function automatic logic lane_hit(input logic [7:0] wdata, input int lane);
    lane_hit = (wdata[slm_pkg::LANE_SEL_LSB +: slm_pkg::LANE_SEL_W] == 3'(lane));
  endfunction

  function automatic logic [7:0] pick_event(input slm_pkg::slm_err_event_t ev, input int t);
    case (t)
      0: pick_event = ev.disparity;
      1: pick_event = ev.table_miss;
      default: pick_event = ev.stray_control;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  logic [COUNT_W-1:0] cnt_q [slm_pkg::NUM_ERR_TYPES][NUM_LANES];
  logic [COUNT_W-1:0] cnt_d [slm_pkg::NUM_ERR_TYPES][NUM_LANES];
  logic [7:0] off_q [slm_pkg::NUM_ERR_TYPES];
  logic [7:0] off_d [slm_pkg::NUM_ERR_TYPES];
  logic [7:0] hit_q [slm_pkg::NUM_ERR_TYPES];
  logic [7:0] hit_d [slm_pkg::NUM_ERR_TYPES];
  logic [7:0] thr_q;
  logic [7:0] thr_d;
  logic [7:0] mask_q;
  logic [7:0] mask_d;
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;
  logic [7:0] cg_q;
  logic [7:0] cg_d;
  logic [7:0] frame_q;
  logic [7:0] frame_d;
  logic [7:0] chk_q;
  logic [7:0] chk_d;
  logic [7:0] vec;
  logic [2:0] rb_lane_q;
  logic [2:0] rb_lane_d;
  slm_pkg::slm_err_type_t rb_type_q;
  slm_pkg::slm_err_type_t rb_type_d;
  logic vec_cg_q;
  logic vec_cg_d;
  logic vec_fr_q;
  logic vec_fr_d;
  logic vec_chk_q;
  logic vec_chk_d;
  logic sync_req_q;
  logic sync_req_d;
  logic irq_q;
  logic irq_d;
  logic [7:0] lane_mask;
  logic [7:0] cg_live;
  logic [7:0] fr_live;
  logic cg_fall;
  logic fr_fall;
  logic chk_bad;
  logic wr_cg_clr;
  logic wr_fr_clr;
  logic wr_chk_clr;

  assign lane_mask = 8'((9'h001 << NUM_LANES) - 9'h001);
  assign cg_live = lane_status_in.code_group_lock & lane_mask;
  assign fr_live = lane_status_in.frame_lock & lane_mask;
  assign cg_fall = |(cg_q & ~cg_live);
  assign fr_fall = |(frame_q & ~fr_live);
  assign chk_bad = |(lane_status_in.checksum_done & ~lane_status_in.checksum_match & lane_mask);
  assign wr_cg_clr = reg_wr_in && reg_addr_in == slm_pkg::ADDR_CODE_GROUP && reg_wdata_in[slm_pkg::IRQ_CLEAR_BIT];
  assign wr_fr_clr = reg_wr_in && reg_addr_in == slm_pkg::ADDR_FRAME && reg_wdata_in[slm_pkg::IRQ_CLEAR_BIT];
  assign wr_chk_clr = reg_wr_in && reg_addr_in == slm_pkg::ADDR_CHECKSUM && reg_wdata_in[slm_pkg::IRQ_CLEAR_BIT];

  ////////////////////////////////////////////////////////////////////////////
  // Error counters, counter-off flags and threshold status per type and lane
  always_comb begin
    logic sel;
    logic [7:0] ev;
    sel = 1'b0;
    ev = 8'h00;
    for (int t = 0; t < slm_pkg::NUM_ERR_TYPES; t++) begin
      sel = reg_wr_in && (reg_addr_in == slm_pkg::ADDR_DISPARITY + 11'(t));
      ev = pick_event(lane_err_in, t);
      off_d[t] = off_q[t];
      hit_d[t] = hit_q[t];
      for (int l = 0; l < NUM_LANES; l++) begin
        cnt_d[t][l] = cnt_q[t][l];
        if (sel && lane_hit(reg_wdata_in, l) && reg_wdata_in[slm_pkg::COUNTER_CLEAR_BIT]) begin
          cnt_d[t][l] = '0;
        end else if (ev[l] && !off_q[t][l] && cnt_q[t][l] != '1) begin
          // Saturates so a hit cannot wrap back below threshold
          cnt_d[t][l] = cnt_q[t][l] + COUNT_W'(1);
        end
        if (sel && lane_hit(reg_wdata_in, l) && reg_wdata_in[slm_pkg::COUNTER_OFF_BIT]) begin
          off_d[t][l] = 1'b1;
        end
        // Set wins over a same-cycle clear
        hit_d[t][l] = (cnt_q[t][l] >= thr_q) ||
          (hit_q[t][l] && !(sel && lane_hit(reg_wdata_in, l) && reg_wdata_in[slm_pkg::IRQ_CLEAR_BIT]));
      end
    end
  end

  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      for (int t = 0; t < slm_pkg::NUM_ERR_TYPES; t++) begin
        off_q[t] <= slm_pkg::REG_RESET;
        hit_q[t] <= slm_pkg::REG_RESET;
        for (int l = 0; l < NUM_LANES; l++) begin
          cnt_q[t][l] <= '0;
        end
      end
    end else begin
      off_q <= off_d;
      hit_q <= hit_d;
      cnt_q <= cnt_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Lock and checksum status, vector flags, sync request and interrupt
  always_comb begin
    cg_d = cg_live;
    frame_d = fr_live;
    chk_d = (chk_q & ~lane_status_in.checksum_done) |
      (lane_status_in.checksum_done & lane_status_in.checksum_match & lane_mask);
    vec_cg_d = cg_fall || (vec_cg_q && !wr_cg_clr);
    vec_fr_d = fr_fall || (vec_fr_q && !wr_fr_clr);
    vec_chk_d = chk_bad || (vec_chk_q && !wr_chk_clr);
    // Lanes not yet locked keep requesting, which restarts the sequence
    sync_req_d = (cg_live != lane_mask) || (fr_live != lane_mask);
    irq_d = |(vec & mask_q);
  end

  always_comb begin
    vec = 8'h00;
    vec[slm_pkg::VEC_CODE_GROUP] = vec_cg_q;
    vec[slm_pkg::VEC_FRAME] = vec_fr_q;
    vec[slm_pkg::VEC_CHECKSUM] = vec_chk_q;
    vec[slm_pkg::VEC_STRAY] = |hit_q[2];
    vec[slm_pkg::VEC_TABLE_MISS] = |hit_q[1];
    vec[slm_pkg::VEC_DISPARITY] = |hit_q[0];
  end

  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      cg_q <= slm_pkg::REG_RESET;
      frame_q <= slm_pkg::REG_RESET;
      chk_q <= slm_pkg::REG_RESET;
      vec_cg_q <= 1'b0;
      vec_fr_q <= 1'b0;
      vec_chk_q <= 1'b0;
      sync_req_q <= 1'b0;
      irq_q <= 1'b0;
    end else begin
      cg_q <= cg_d;
      frame_q <= frame_d;
      chk_q <= chk_d;
      vec_cg_q <= vec_cg_d;
      vec_fr_q <= vec_fr_d;
      vec_chk_q <= vec_chk_d;
      sync_req_q <= sync_req_d;
      irq_q <= irq_d;
    end
  end

  assign sync_request_output_n_out = ~sync_req_q;
  assign irq_n_out = ~irq_q;

  ////////////////////////////////////////////////////////////////////////////
  // Register port: plain writes, registered read data
  always_comb begin
    thr_d = thr_q;
    mask_d = mask_q;
    rb_lane_d = rb_lane_q;
    rb_type_d = rb_type_q;
    rdata_d = rdata_q;
    if (reg_wr_in) begin
      case (reg_addr_in)
        slm_pkg::ADDR_THRESHOLD: thr_d = reg_wdata_in;
        slm_pkg::ADDR_IRQ_VECTOR: mask_d = reg_wdata_in;
        slm_pkg::ADDR_ERR_READBACK: begin
          rb_lane_d = reg_wdata_in[slm_pkg::READBACK_LANE_LSB +: 3];
          rb_type_d = slm_pkg::slm_err_type_t'(reg_wdata_in[slm_pkg::READBACK_TYPE_LSB +: 2]);
        end
        default: ;
      endcase
    end
    if (reg_rd_in) begin
      case (reg_addr_in)
        slm_pkg::ADDR_ERR_READBACK: begin
          if (32'(rb_lane_q) < NUM_LANES && rb_type_q != 2'b11) begin
            rdata_d = cnt_q[rb_type_q][rb_lane_q];
          end else begin
            rdata_d = 8'h00;
          end
        end
        slm_pkg::ADDR_DISPARITY: rdata_d = hit_q[0];
        slm_pkg::ADDR_TABLE_MISS: rdata_d = hit_q[1];
        slm_pkg::ADDR_STRAY_CONTROL: rdata_d = hit_q[2];
        slm_pkg::ADDR_CODE_GROUP: rdata_d = cg_q;
        slm_pkg::ADDR_FRAME: rdata_d = frame_q;
        slm_pkg::ADDR_CHECKSUM: rdata_d = chk_q;
        slm_pkg::ADDR_IRQ_VECTOR: rdata_d = vec;
        slm_pkg::ADDR_THRESHOLD: rdata_d = thr_q;
        default: rdata_d = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      thr_q <= slm_pkg::THRESHOLD_RESET;
      mask_q <= slm_pkg::REG_RESET;
      rb_lane_q <= 3'h0;
      rb_type_q <= slm_pkg::SLM_ERR_DISPARITY;
      rdata_q <= slm_pkg::REG_RESET;
    end else begin
      thr_q <= thr_d;
      mask_q <= mask_d;
      rb_lane_q <= rb_lane_d;
      rb_type_q <= rb_type_d;
      rdata_q <= rdata_d;
    end
  end

  assign reg_rdata_out = rdata_q;

  ////////////////////////////////////////////////////////////////////////////
  AST_CG_FLAG_SET: assert property (@(posedge clock_in) disable iff (!nrst_in)
    cg_fall |=> vec_cg_q) else $error("code group loss did not set flag");
  AST_CG_FLAG_CLEAR: assert property (@(posedge clock_in) disable iff (!nrst_in)
    (wr_cg_clr && !cg_fall) |=> !vec_cg_q) else $error("code group flag not cleared");
  AST_SYNC_REQ: assert property (@(posedge clock_in) disable iff (!nrst_in)
    (cg_live != lane_mask) |=> !sync_request_output_n_out) else $error("sync request missing");
  AST_FRAME_RESYNC: assert property (@(posedge clock_in) disable iff (!nrst_in)
    fr_fall |=> !sync_request_output_n_out && vec_fr_q) else $error("frame loss not handled");
  AST_CHK_FLAG: assert property (@(posedge clock_in) disable iff (!nrst_in)
    chk_bad |=> vec_chk_q ##0 $past(chk_bad)) else $error("checksum flag missing");
  AST_IRQ_OUT: assert property (@(posedge clock_in) disable iff (!nrst_in)
    (mask_q[slm_pkg::VEC_DISPARITY] && |hit_q[0]) |=> !irq_n_out) else $error("interrupt not low");
  AST_CNT_CLEAR: assert property (@(posedge clock_in) disable iff (!nrst_in)
    (reg_wr_in && reg_addr_in == slm_pkg::ADDR_DISPARITY && reg_wdata_in == 8'h20) |=> cnt_q[0][0] == '0)
    else $error("lane 0 counter not zeroed");
  AST_CNT_OFF: assert property (@(posedge clock_in) disable iff (!nrst_in)
    (off_q[0][0] && !(reg_wr_in && reg_addr_in == slm_pkg::ADDR_DISPARITY)) |=> $stable(cnt_q[0][0]))
    else $error("disabled counter moved");
  AST_READBACK: assert property (@(posedge clock_in) disable iff (!nrst_in)
    (reg_rd_in && reg_addr_in == slm_pkg::ADDR_ERR_READBACK && rb_lane_q == 3'h0 && rb_type_q == slm_pkg::SLM_ERR_DISPARITY)
    |=> reg_rdata_out == $past(cnt_q[0][0])) else $error("readback mismatch");
  AST_HIT_SET: assert property (@(posedge clock_in) disable iff (!nrst_in)
    (cnt_q[1][0] >= thr_q) |=> hit_q[1][0]) else $error("table miss status not set");

  AST_FR_FLAG_CLEAR: assert property (@(posedge clock_in) disable iff (!nrst_in)
    (wr_fr_clr && !fr_fall) |=> !vec_fr_q)
    else $error("frame flag not cleared");

  AST_CHK_FLAG_CLEAR: assert property (@(posedge clock_in) disable iff (!nrst_in)
    (wr_chk_clr && !chk_bad) |=> !vec_chk_q)
    else $error("checksum flag not cleared");

  AST_CG_LIVE: assert property (@(posedge clock_in) disable iff (!nrst_in)
    1'b1 |=> cg_q == $past(cg_live))
    else $error("code group bits not live");

  AST_FR_LIVE: assert property (@(posedge clock_in) disable iff (!nrst_in)
    1'b1 |=> frame_q == $past(fr_live))
    else $error("frame bits not live");

  AST_CHK_MATCH: assert property (@(posedge clock_in) disable iff (!nrst_in)
    (lane_status_in.checksum_done[0] && lane_status_in.checksum_match[0]) |=> chk_q[0])
    else $error("checksum match bit not set");

  AST_CHK_MISS: assert property (@(posedge clock_in) disable iff (!nrst_in)
    (lane_status_in.checksum_done[0] && !lane_status_in.checksum_match[0]) |=> !chk_q[0])
    else $error("checksum match bit not cleared");

  AST_DIS_IRQ_CLEAR: assert property (@(posedge clock_in) disable iff (!nrst_in)
    (reg_wr_in && reg_addr_in == slm_pkg::ADDR_DISPARITY && reg_wdata_in[7] && reg_wdata_in[2:0] == 3'h0 &&
    cnt_q[0][0] < thr_q) |=> !hit_q[0][0]) else $error("disparity status not cleared");

  AST_NIT_IRQ_CLEAR: assert property (@(posedge clock_in) disable iff (!nrst_in)
    (reg_wr_in && reg_addr_in == slm_pkg::ADDR_TABLE_MISS && reg_wdata_in[7] && reg_wdata_in[2:0] == 3'h0 &&
    cnt_q[1][0] < thr_q) |=> !hit_q[1][0]) else $error("table miss status not cleared");

  AST_UCC_IRQ_CLEAR: assert property (@(posedge clock_in) disable iff (!nrst_in)
    (reg_wr_in && reg_addr_in == slm_pkg::ADDR_STRAY_CONTROL && reg_wdata_in[7] && reg_wdata_in[2:0] == 3'h0 &&
    cnt_q[2][0] < thr_q) |=> !hit_q[2][0]) else $error("stray control status not cleared");

  AST_OFF_SET: assert property (@(posedge clock_in) disable iff (!nrst_in)
    (reg_wr_in && reg_addr_in == slm_pkg::ADDR_DISPARITY && reg_wdata_in[6] && reg_wdata_in[2:0] == 3'h0)
    |=> off_q[0][0]) else $error("counter off not taken");

  AST_NIT_CNT_CLEAR: assert property (@(posedge clock_in) disable iff (!nrst_in)
    (reg_wr_in && reg_addr_in == slm_pkg::ADDR_TABLE_MISS && reg_wdata_in[5] && reg_wdata_in[2:0] == 3'h0)
    |=> cnt_q[1][0] == '0) else $error("table miss counter not zeroed");

  AST_UCC_CNT_CLEAR: assert property (@(posedge clock_in) disable iff (!nrst_in)
    (reg_wr_in && reg_addr_in == slm_pkg::ADDR_STRAY_CONTROL && reg_wdata_in[5] && reg_wdata_in[2:0] == 3'h0)
    |=> cnt_q[2][0] == '0) else $error("stray control counter not zeroed");

  AST_LANE_SELECT: assert property (@(posedge clock_in) disable iff (!nrst_in)
    (reg_wr_in && reg_addr_in == slm_pkg::ADDR_DISPARITY && reg_wdata_in[5] && reg_wdata_in[2:0] != 3'h0 &&
    !lane_err_in.disparity[0]) |=> $stable(cnt_q[0][0])) else $error("wrong lane counter cleared");

  AST_STRAY_HIT: assert property (@(posedge clock_in) disable iff (!nrst_in)
    (cnt_q[2][0] >= thr_q) |=> hit_q[2][0])
    else $error("stray control status not set");

  AST_IRQ_QUIET: assert property (@(posedge clock_in) disable iff (!nrst_in)
    ((vec & mask_q) == 8'h00) |=> irq_n_out)
    else $error("interrupt low without cause");

  AST_SYNC_IDLE: assert property (@(posedge clock_in) disable iff (!nrst_in)
    (cg_live == lane_mask && fr_live == lane_mask) |=> sync_request_output_n_out)
    else $error("sync request without loss");

  AST_STROBE_READ: assert property (@(posedge clock_in) disable iff (!nrst_in)
    (reg_rd_in && reg_addr_in == slm_pkg::ADDR_TABLE_MISS) |=> reg_rdata_out == $past(hit_q[1]))
    else $error("shared address read not status");
endmodule // slm_monitor

//--- shared/slm_pkg.sv
// Function
// - Disparity write bit 7 clears addressed lane interrupt
// - Disparity write bit 6 stops addressed lane counter
// - Disparity write bit 5 zeroes addressed lane counter
// - Bits 2..0 pick lane for strobes 7..5
// - Table-miss status bit per lane at threshold
// - Table-miss writes: clear, counter off, counter reset
// - Stray-control status bit per lane at threshold
// - Stray-control writes: clear, counter off, counter reset
// - Code group lock bit per lane
// - Code group loss sets vector bit 0
// - Any code group loss asserts sync request
// - Live frame lock bits, bit 7 write clears
// - Frame lock loss restarts synchronization request
// - Checksum match per lane, mismatch sets bit 2
// - Checksum bit 7 write clears its interrupt
// - All status and control reset to zero, except threshold, which resets to FF
// - Enabled disparity threshold hit pulls interrupt low
// - Readback returns selected lane and counter
package slm_pkg;
  localparam logic [10:0] ADDR_ERR_READBACK = 11'h46B;
  localparam logic [10:0] ADDR_DISPARITY = 11'h46D;
  localparam logic [10:0] ADDR_TABLE_MISS = 11'h46E;
  localparam logic [10:0] ADDR_STRAY_CONTROL = 11'h46F;
  localparam logic [10:0] ADDR_CODE_GROUP = 11'h470;
  localparam logic [10:0] ADDR_FRAME = 11'h471;
  localparam logic [10:0] ADDR_CHECKSUM = 11'h472;
  localparam logic [10:0] ADDR_IRQ_VECTOR = 11'h47A;
  localparam logic [10:0] ADDR_THRESHOLD = 11'h47C;
  localparam int IRQ_CLEAR_BIT = 7;
  localparam int COUNTER_OFF_BIT = 6;
  localparam int COUNTER_CLEAR_BIT = 5;
  localparam int LANE_SEL_LSB = 0;
  localparam int LANE_SEL_W = 3;
  localparam int READBACK_LANE_LSB = 4;
  localparam int READBACK_TYPE_LSB = 0;
  localparam int VEC_CODE_GROUP = 0;
  localparam int VEC_FRAME = 1;
  localparam int VEC_CHECKSUM = 2;
  localparam int VEC_STRAY = 5;
  localparam int VEC_TABLE_MISS = 6;
  localparam int VEC_DISPARITY = 7;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [7:0] THRESHOLD_RESET = 8'hFF;
  localparam int NUM_ERR_TYPES = 3;

  typedef enum logic [1:0] {
    SLM_ERR_DISPARITY = 2'b00,
    SLM_ERR_TABLE_MISS = 2'b01,
    SLM_ERR_STRAY_CONTROL = 2'b10
  } slm_err_type_t;

  typedef struct packed {
    logic [7:0] disparity;
    logic [7:0] table_miss;
    logic [7:0] stray_control;
  } slm_err_event_t;

  typedef struct packed {
    logic [7:0] code_group_lock;
    logic [7:0] frame_lock;
    logic [7:0] checksum_match;
    logic [7:0] checksum_done;
  } slm_lane_status_t;
endpackage

//--- verification/slm_lane_source.sv
`timescale 1ns/100ps
module slm_lane_source #(
  parameter int RESYNC_CYCLES = 4
) (
  input wire logic clock_in,
  input wire logic sync_req_n_in,
  output slm_pkg::slm_err_event_t err_out,
  output slm_pkg::slm_lane_status_t status_out
);
  logic [7:0] cg_drop = 8'h00;
  logic [7:0] fr_drop = 8'h00;
  int wait_q = 0;
  initial err_out = '0;
  initial status_out = '0;
  ////////////////////////////////////////////////////////////
  // Retrain on request; broken lanes stay down, so no kinder than real
  always @(posedge clock_in) begin
    #1;
    wait_q = sync_req_n_in ? 0 : wait_q + 1;
    status_out.code_group_lock = status_out.code_group_lock & ~cg_drop;
    status_out.frame_lock = status_out.frame_lock & ~fr_drop;
    if (wait_q > 0 && wait_q % RESYNC_CYCLES == 0) begin
      status_out.code_group_lock = ~cg_drop;
      status_out.frame_lock = ~fr_drop;
    end
  end
  ////////////////////////////////////////////////////////////
  task automatic err_pulse(input int t, input int lane);
    logic [23:0] v;
    v = '0;
    v[(2 - t) * 8 + lane] = 1'b1;
    err_out = v;
    @(posedge clock_in);
    #1;
    err_out = '0;
    @(posedge clock_in);
    #1;
  endtask
  task automatic csum(input int lane, input bit ok);
    status_out.checksum_match[lane] = ok;
    status_out.checksum_done[lane] = 1'b1;
    @(posedge clock_in);
    #1;
    status_out.checksum_done = 8'h00;
  endtask
endmodule // slm_lane_source

//--- verification/slm_monitor_bench.sv
`timescale 1ns/100ps
module slm_monitor_bench;
  logic clock_in = 1'b0;
  logic nrst_in = 1'b0;
  logic [10:0] addr = 11'h000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:0] wdata = 8'h00;
  logic [7:0] rdata;
  slm_pkg::slm_err_event_t err;
  slm_pkg::slm_lane_status_t status;
  logic sync_n;
  logic irq_n;
  int errors = 0;
  int checks = 0;
  int cnt [3][8];
  int thr;
  int lane;
  logic [10:0] a;
  always #20 clock_in = ~clock_in;
  slm_monitor i_dut (.clock_in(clock_in), .nrst_in(nrst_in), .reg_addr_in(addr), .reg_wr_in(wr),
    .reg_rd_in(rd), .reg_wdata_in(wdata), .reg_rdata_out(rdata), .lane_err_in(err),
    .lane_status_in(status), .sync_request_output_n_out(sync_n), .irq_n_out(irq_n));
  slm_lane_source i_src (.clock_in(clock_in), .sync_req_n_in(sync_n), .err_out(err), .status_out(status));
  ////////////////////////////////////////////////////////////
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    checks++;
    if (g !== e) begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clock_in);
    #1;
  endtask
  task automatic wr_reg(input logic [10:0] ad, input logic [7:0] d);
    addr = ad;
    wdata = d;
    wr = 1'b1;
    step(1);
    wr = 1'b0;
    step(1);
  endtask
  // Sample one edge after the read edge; data stands until next read
  task automatic chk_reg(input logic [10:0] ad, input logic [7:0] e);
    addr = ad;
    rd = 1'b1;
    step(1);
    rd = 1'b0;
    step(1);
    chk(rdata, e);
  endtask
  task automatic chk_cnt(input int t, input int ln);
    wr_reg(slm_pkg::ADDR_ERR_READBACK, 8'((ln << 4) | t));
    chk_reg(slm_pkg::ADDR_ERR_READBACK, 8'(cnt[t][ln]));
  endtask
  task automatic lock_loss(input int f);
    lane = $urandom_range(7);
    if (f == 0) i_src.cg_drop = 8'h01 << lane;
    else i_src.fr_drop = 8'h01 << lane;
    // Source samples the drop at the same delay, so allow one extra edge
    step(3);
    chk({7'h00, sync_n}, 8'h00);
    chk_reg(slm_pkg::ADDR_CODE_GROUP + 11'(f), ~(8'h01 << lane));
    chk_reg(slm_pkg::ADDR_IRQ_VECTOR, 8'h01 << f);
    i_src.cg_drop = 8'h00;
    i_src.fr_drop = 8'h00;
    step(12);
    chk({7'h00, sync_n}, 8'h01);
    wr_reg(slm_pkg::ADDR_CODE_GROUP + 11'(f), 8'h80);
    chk_reg(slm_pkg::ADDR_IRQ_VECTOR, 8'h00);
  endtask
  task automatic wrap_up();
    $display("Comparisons %0d, mismatches %0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    #400000;
    errors++;
    wrap_up();
  end
  initial begin
    void'($urandom(32'h0256fa3f));
    cnt = '{default: 0};
    step(10);
    nrst_in = 1'b1;
    for (int r = 0; r < 3; r++) chk_reg(slm_pkg::ADDR_DISPARITY + 11'(r), 8'h00);
    chk_reg(slm_pkg::ADDR_IRQ_VECTOR, 8'h00);
    chk({7'h00, irq_n}, 8'h01);
    step(10);
    chk_reg(slm_pkg::ADDR_CODE_GROUP, 8'hFF);
    chk_reg(slm_pkg::ADDR_FRAME, 8'hFF);
    chk({7'h00, sync_n}, 8'h01);
    thr = 2 + $urandom_range(2);
    wr_reg(slm_pkg::ADDR_THRESHOLD, 8'(thr));
    wr_reg(slm_pkg::ADDR_IRQ_VECTOR, 8'hE0);
    for (int t = 0; t < 3; t++) begin
      lane = $urandom_range(7);
      a = slm_pkg::ADDR_DISPARITY + 11'(t);
      for (int i = 0; i < thr; i++) begin
        i_src.err_pulse(t, lane);
        cnt[t][lane]++;
      end
      step(2);
      chk_reg(a, 8'h01 << lane);
      chk({7'h00, irq_n}, 8'h00);
      chk_cnt(t, lane);
      wr_reg(a, 8'(32'h20 | lane));
      i_src.err_pulse(t, lane);
      cnt[t][lane] = 1;
      chk_cnt(t, lane);
      wr_reg(a, 8'(32'h80 | (lane ^ 1)));
      chk_reg(a, 8'h01 << lane);
      wr_reg(a, 8'(32'h80 | lane));
      chk_reg(a, 8'h00);
      chk({7'h00, irq_n}, 8'h01);
      wr_reg(a, 8'(32'h40 | lane));
      for (int i = 0; i < thr; i++) i_src.err_pulse(t, lane);
      step(2);
      chk_cnt(t, lane);
      chk_reg(a, 8'h00);
    end
    lock_loss(0);
    lock_loss(1);
    lane = $urandom_range(7);
    i_src.csum(lane, 1'b1);
    chk_reg(slm_pkg::ADDR_CHECKSUM, 8'h01 << lane);
    i_src.csum(lane, 1'b0);
    chk_reg(slm_pkg::ADDR_CHECKSUM, 8'h00);
    chk_reg(slm_pkg::ADDR_IRQ_VECTOR, 8'h04);
    wr_reg(slm_pkg::ADDR_CHECKSUM, 8'h80);
    chk_reg(slm_pkg::ADDR_IRQ_VECTOR, 8'h00);
    wrap_up();
  end
endmodule // slm_monitor_bench
